// ===== design/tape_pkg.sv
// Functional notes
// - all timing from a 2.048 MHz oscillator
// - divide oscillator by sixteen for 128 kHz
// - phase one at count eight, two at sixteen
// - toggle halves phase one into two sub-phases
// - phase encoding, two transitions per bit cell
// - strobe count three marks sync and bit timing
// - read bits shift into eight-bit shifter
// - parallel load in second half of bit nine
// - ten bit frame, double-width parity, final clock
// - write loads eight bits, shifts out, adds parity
// - exactly one track enabled, read or write
// - read path ignored while writing
// - read data latched at each strobe
// - parallel bytes to host, serial to deck
// Purpose: shared constants and types for the tape character path
// Assumes: clk_sys at 10 MHz, oscillator rate made by a fractional enable
// Notes:   design counts derived here; the deck model hard codes its strobe and cell timing
package tape_pkg;
  localparam int         CLK_HZ      = 10_000_000;
  localparam int         OSC_HZ      = 2_048_000;
  // fractional step: osc/1000 over clk/1000 keeps the accumulator small
  localparam int         ACC_W       = 15;
  localparam logic [14:0] OSC_STEP   = 15'(OSC_HZ / 1000);
  localparam logic [14:0] ACC_MOD    = 15'(CLK_HZ / 1000);
  localparam logic [3:0] BASE_LAST   = 4'hF;  // divide by sixteen
  localparam logic [3:0] PHI1_CNT    = 4'h7;  // eighth count of base clock
  localparam logic [3:0] PHI2_CNT    = 4'hF;  // sixteenth count
  localparam logic [1:0] SYNC_COUNT  = 2'h3;  // strobes per first full bit
  localparam logic [1:0] STB_RELOAD  = 2'h1;  // later bits every two strobes
  localparam int         CHAR_BITS   = 8;
  localparam logic [3:0] DATA_LAST   = 4'h8;
  localparam logic [3:0] LOAD_BIT    = 4'h9;
  localparam logic [3:0] FRAME_BITS  = 4'hA;
  localparam logic       PARITY_ODD  = 1'b1;
  localparam int         FIFO_DEPTH  = 8;

  typedef enum logic [1:0] {RD_HUNT = 2'b01, RD_FRAME = 2'b10} rd_state_t;
  typedef enum logic [1:0] {WR_IDLE = 2'b01, WR_SEND = 2'b10} wr_state_t;
endpackage : tape_pkg

// ===== design/phase_if.sv
// Purpose: carries the clock-phase enables between timing and data logic
// Assumes: all members are one-cycle pulses on clk_sys
// Notes:   none
`timescale 1ns/1ps
`default_nettype none
interface phase_if;
  logic oscEn;
  logic baseEn;
  logic phi1;
  logic phi2;
  logic phi1A;
  logic phi1B;
  modport src (output oscEn, output baseEn, output phi1, output phi2, output phi1A, output phi1B);
  modport snk (input oscEn, input baseEn, input phi1, input phi2, input phi1A, input phi1B);
endinterface : phase_if
`default_nettype wire

// ===== design/phase_gen.sv
// Purpose: oscillator enable, base divider and phase generator
// Assumes: one clock; every slower rate is an enable pulse
// Notes:   oscillator pulses jitter by one cycle, average rate exact
`timescale 1ns/1ps
`default_nettype none
module phase_gen (
  input  wire logic clk_sys,
  input  wire logic reset,
  phase_if.src      ph
);
  import tape_pkg::*;

  typedef struct packed {
    logic [14:0] acc;
    logic [3:0]  div;
    logic [3:0]  cnt;
    logic        tog;
    logic        oscEn;
    logic        baseEn;
    logic        phi1;
    logic        phi2;
    logic        phi1A;
    logic        phi1B;
  } pg_state_t;

  pg_state_t st_r, st_nxt;
  logic [14:0] sum;

  always_comb begin
    st_nxt = st_r;
    st_nxt.oscEn  = 1'b0;
    st_nxt.baseEn = 1'b0;
    st_nxt.phi1   = 1'b0;
    st_nxt.phi2   = 1'b0;
    st_nxt.phi1A  = 1'b0;
    st_nxt.phi1B  = 1'b0;
    sum = st_r.acc + OSC_STEP;
    if (sum >= ACC_MOD) begin
      st_nxt.acc   = sum - ACC_MOD;
      st_nxt.oscEn = 1'b1;
    end else begin
      st_nxt.acc = sum;
    end
    if (st_r.oscEn) begin
      st_nxt.div    = st_r.div + 4'h1;
      st_nxt.baseEn = (st_r.div == BASE_LAST);
    end
    if (st_r.baseEn) begin
      st_nxt.cnt  = st_r.cnt + 4'h1;
      st_nxt.phi1 = (st_r.cnt == PHI1_CNT);
      st_nxt.phi2 = (st_r.cnt == PHI2_CNT);
    end
    if (st_r.phi1) begin
      st_nxt.tog   = ~st_r.tog;
      st_nxt.phi1A = ~st_r.tog;
      st_nxt.phi1B = st_r.tog;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ph.oscEn  = st_r.oscEn;
  assign ph.baseEn = st_r.baseEn;
  assign ph.phi1   = st_r.phi1;
  assign ph.phi2   = st_r.phi2;
  assign ph.phi1A  = st_r.phi1A;
  assign ph.phi1B  = st_r.phi1B;

  base_after_osc_a: assert property (@(posedge clk_sys) disable iff (reset)
    st_r.baseEn |-> $past(st_r.oscEn) && $past(st_r.div) == BASE_LAST)
    else $error("base enable without sixteenth oscillator pulse");
  phases_apart_a: assert property (@(posedge clk_sys) disable iff (reset)
    st_r.phi1 |-> !st_r.phi2 ##1 !st_r.phi2 [*8])
    else $error("phase two too close to phase one");
  subphase_split_a: assert property (@(posedge clk_sys) disable iff (reset)
    st_r.phi1 |=> (st_r.phi1A ^ st_r.phi1B) && (st_r.phi1B == $past(st_r.tog)))
    else $error("sub-phase not derived from toggle");
endmodule : phase_gen
`default_nettype wire

// ===== design/char_fifo.sv
// Purpose: small character buffer between host and write serializer
// Assumes: single clock, simultaneous push and pop allowed
// Notes:   flags registered so ready leaves straight from a flop
`timescale 1ns/1ps
`default_nettype none
module char_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
    logic                    notFull;
    logic                    notEmpty;
  } fifo_state_t;

  fifo_state_t st_r, st_nxt;
  logic push, pop;

  always_comb begin
    st_nxt = st_r;
    push = inValid & st_r.notFull;
    pop  = outReady & st_r.notEmpty;
    if (push) begin
      st_nxt.mem[st_r.wp] = inData;
      st_nxt.wp = (st_r.wp == AW'(DEPTH - 1)) ? '0 : st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = (st_r.rp == AW'(DEPTH - 1)) ? '0 : st_r.rp + 1'b1;
    end
    st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    st_nxt.notFull  = (st_nxt.cnt != (AW+1)'(DEPTH));
    st_nxt.notEmpty = (st_nxt.cnt != '0);
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_r <= '0;
      st_r.notFull <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign inReady  = st_r.notFull;
  assign outValid = st_r.notEmpty;
  assign outData  = st_r.mem[st_r.rp];
endmodule : char_fifo
`default_nettype wire

// ===== design/tape_char_serdes_timing.sv
// Purpose: character timing, read deserializer and write serializer
// Assumes: deck pins synchronous to clk_sys; strobe arrives active low
// Notes:   host bytes pass through an 8-word buffer before serializing
`timescale 1ns/1ps
`default_nettype none
module tape_char_serdes_timing (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic [7:0] hostWrData,
  input  wire logic       hostWrValid,
  output logic            hostWrReady,
  output logic [7:0]      hostRdData,
  output logic            hostRdValid,
  output logic            parityErr,
  output logic            rdSynced,
  input  wire logic       rdStrobeN,
  input  wire logic       rdLevel,
  input  wire logic       trackSelB,
  input  wire logic       writeMode,
  output logic            trackAEn,
  output logic            trackBEn,
  output logic            trackWrite,
  output logic            wrSerial,
  output logic            wrActive,
  input  wire logic       dirIn,
  input  wire logic       speedIn,
  input  wire logic       runIn,
  output logic            dirOut,
  output logic            speedOut,
  output logic            runOut
);
  import tape_pkg::*;

  function automatic logic parity_of(input logic [7:0] d);
    parity_of = (^d) ^ PARITY_ODD;
  endfunction : parity_of

  typedef struct packed {
    rd_state_t  rdState;
    logic       stbPrev;
    logic [1:0] stbCnt;
    logic       rdLatch;
    logic [3:0] bitCnt;
    logic [7:0] rdShift;
    logic       rdParA;
    logic [7:0] rdData;
    logic       rdValid;
    logic       parErr;
    wr_state_t  wrState;
    logic [7:0] wrShift;
    logic       wrPar;
    logic [3:0] wrIdx;
    logic       wrSer;
    logic       trkA;
    logic       trkB;
    logic       trkW;
    logic       dir;
    logic       speed;
    logic       run;
  } top_state_t;

  top_state_t st_r, st_nxt;
  phase_if    ph ();

  logic       fifoValid;
  logic       fifoPop;
  logic [7:0] fifoData;
  logic       stbEdge;
  logic       bitTick;
  logic       levelNow;
  logic       wrBit;

  phase_gen u_phase (
    .clk_sys (clk_sys),
    .reset   (reset),
    .ph      (ph)
  );

  // host writes stall here when the buffer is full
  char_fifo #(.W(CHAR_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .inValid  (hostWrValid),
    .inReady  (hostWrReady),
    .inData   (hostWrData),
    .outValid (fifoValid),
    .outReady (fifoPop),
    .outData  (fifoData)
  );

  // pop only at a bit boundary so a new character starts cleanly
  assign fifoPop = ph.phi1 & st_r.trkW & fifoValid &
                   ((st_r.wrState == WR_IDLE) ||
                    (st_r.wrState == WR_SEND && st_r.wrIdx == LOAD_BIT));

  always_comb begin
    st_nxt = st_r;
    st_nxt.rdValid = 1'b0;
    bitTick  = 1'b0;
    wrBit    = 1'b0;
    // strobe arrives low active; inverted before counting
    stbEdge  = ~rdStrobeN & ~st_r.stbPrev;
    st_nxt.stbPrev = ~rdStrobeN;
    levelNow = st_r.rdLatch;

    st_nxt.trkA = ~trackSelB;
    st_nxt.trkB = trackSelB;
    st_nxt.trkW = writeMode;
    st_nxt.dir   = dirIn;
    st_nxt.speed = speedIn;
    st_nxt.run   = runIn;

    if (st_r.trkW) begin
      // write head noise reaches the read amplifier; drop it all
      st_nxt.rdState = RD_HUNT;
      st_nxt.stbCnt  = 2'h0;
      st_nxt.bitCnt  = 4'h0;
    end else if (stbEdge) begin
      levelNow = rdLevel;
      st_nxt.rdLatch = rdLevel;
      if (st_r.stbCnt + 2'h1 == SYNC_COUNT) begin
        bitTick = 1'b1;
        st_nxt.stbCnt = STB_RELOAD;
      end else begin
        st_nxt.stbCnt = st_r.stbCnt + 2'h1;
      end
    end

    if (bitTick) begin
      unique case (st_r.rdState)
        RD_HUNT: begin
          st_nxt.rdState = RD_FRAME;
          st_nxt.bitCnt  = 4'h0;
        end
        RD_FRAME: begin
          st_nxt.bitCnt = st_r.bitCnt + 4'h1;
          if (st_r.bitCnt < DATA_LAST) begin
            st_nxt.rdShift = {st_r.rdShift[6:0], levelNow};
          end
          if (st_r.bitCnt == DATA_LAST) begin
            st_nxt.rdParA  = levelNow;
            st_nxt.rdData  = st_r.rdShift;
            st_nxt.rdValid = 1'b1;
          end
          if (st_r.bitCnt == LOAD_BIT) begin
            // second parity cell closes the character
            st_nxt.parErr = (st_r.rdParA != levelNow) ||
                            (levelNow != parity_of(st_r.rdData));
            st_nxt.bitCnt = 4'h0;
          end
        end
      endcase
    end

    unique case (st_r.wrState)
      WR_IDLE: begin
        if (fifoPop) begin
          st_nxt.wrState = WR_SEND;
          st_nxt.wrShift = fifoData;
          st_nxt.wrPar   = parity_of(fifoData);
          st_nxt.wrIdx   = 4'h0;
          st_nxt.wrSer   = ~fifoData[7];
        end
      end
      WR_SEND: begin
        wrBit = (st_r.wrIdx < DATA_LAST) ? st_r.wrShift[7] : st_r.wrPar;
        if (ph.phi2) begin
          st_nxt.wrSer = wrBit;
        end
        if (ph.phi1) begin
          if (fifoPop) begin
            st_nxt.wrShift = fifoData;
            st_nxt.wrPar   = parity_of(fifoData);
            st_nxt.wrIdx   = 4'h0;
            st_nxt.wrSer   = ~fifoData[7];
          end else if (st_r.wrIdx == LOAD_BIT) begin
            st_nxt.wrState = WR_IDLE;
            st_nxt.wrIdx   = 4'h0;
          end else begin
            st_nxt.wrIdx = st_r.wrIdx + 4'h1;
            if (st_r.wrIdx < DATA_LAST) begin
              st_nxt.wrShift = {st_r.wrShift[6:0], 1'b0};
            end
            st_nxt.wrSer = (st_r.wrIdx + 4'h1 < DATA_LAST) ?
                           ~st_r.wrShift[6] : ~st_r.wrPar;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_r <= '0;
      st_r.rdState <= RD_HUNT;
      st_r.wrState <= WR_IDLE;
      st_r.trkA    <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hostRdData  = st_r.rdData;
  assign hostRdValid = st_r.rdValid;
  assign parityErr   = st_r.parErr;
  assign rdSynced    = st_r.rdState[1];  // one-hot frame bit, straight from its flop
  assign trackAEn    = st_r.trkA;
  assign trackBEn    = st_r.trkB;
  assign trackWrite  = st_r.trkW;
  assign wrSerial    = st_r.wrSer;
  assign wrActive    = st_r.wrState[1];
  assign dirOut      = st_r.dir;
  assign speedOut    = st_r.speed;
  assign runOut      = st_r.run;

  track_onehot_a: assert property (@(posedge clk_sys) disable iff (reset)
    trackAEn ^ trackBEn)
    else $error("track enables not one-hot");
  read_muted_a: assert property (@(posedge clk_sys) disable iff (reset)
    trackWrite |=> !hostRdValid && !rdSynced)
    else $error("read activity during write");
  load_at_nine_a: assert property (@(posedge clk_sys) disable iff (reset)
    hostRdValid |-> st_r.bitCnt == LOAD_BIT && rdSynced)
    else $error("parallel load outside bit nine");
  strobe_count_a: assert property (@(posedge clk_sys) disable iff (reset)
    st_r.stbCnt != SYNC_COUNT)
    else $error("strobe counter passed three");
  frame_range_a: assert property (@(posedge clk_sys) disable iff (reset)
    st_r.bitCnt < FRAME_BITS)
    else $error("bit counter beyond frame");
  latch_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
    !stbEdge |=> $stable(st_r.rdLatch))
    else $error("read level changed without strobe");
  mid_bit_a: assert property (@(posedge clk_sys) disable iff (reset)
    wrActive && ph.phi2 && !ph.phi1 |=> wrSerial == $past(wrBit))
    else $error("mid-cell write level wrong");
  write_load_a: assert property (@(posedge clk_sys) disable iff (reset)
    fifoPop |=> wrActive && st_r.wrIdx == 4'h0 && st_r.wrPar == parity_of(st_r.wrShift))
    else $error("write character not loaded with parity");

  track_follow_a: assert property (@(posedge clk_sys) disable iff (reset)
    1'b1 |=> trackBEn == $past(trackSelB) && trackWrite == $past(writeMode))
    else $error("track select not registered");
  motor_copy_a: assert property (@(posedge clk_sys) disable iff (reset)
    1'b1 |=> {dirOut, speedOut, runOut} == $past({dirIn, speedIn, runIn}))
    else $error("motor controls not passed on");
  sync_found_a: assert property (@(posedge clk_sys) disable iff (reset)
    bitTick && !rdSynced |=> rdSynced && st_r.bitCnt == 4'h0)
    else $error("sync tick did not start a frame");
  strobe_tick_a: assert property (@(posedge clk_sys) disable iff (reset)
    stbEdge && !trackWrite && st_r.stbCnt == 2'h2 |-> bitTick)
    else $error("third strobe gave no bit tick");
  shift_in_a: assert property (@(posedge clk_sys) disable iff (reset)
    bitTick && rdSynced && st_r.bitCnt < DATA_LAST |=> st_r.rdShift[0] == $past(rdLevel))
    else $error("read bit not shifted in");
  latch_on_strobe_a: assert property (@(posedge clk_sys) disable iff (reset)
    stbEdge && !trackWrite |=> st_r.rdLatch == $past(rdLevel))
    else $error("read level not latched at strobe");
  load_data_a: assert property (@(posedge clk_sys) disable iff (reset)
    hostRdValid |-> hostRdData == st_r.rdShift)
    else $error("loaded character differs from shifter");
  frame_wrap_a: assert property (@(posedge clk_sys) disable iff (reset)
    bitTick && rdSynced && st_r.bitCnt == LOAD_BIT |=> rdSynced && st_r.bitCnt == 4'h0)
    else $error("frame did not close after ten bits");
  parity_mismatch_a: assert property (@(posedge clk_sys) disable iff (reset)
    bitTick && rdSynced && st_r.bitCnt == LOAD_BIT && rdLevel != st_r.rdParA |=> parityErr)
    else $error("unequal parity cells not flagged");
  hunt_quiet_a: assert property (@(posedge clk_sys) disable iff (reset)
    !rdSynced |=> !hostRdValid)
    else $error("character delivered before sync");
  tick_unmuted_a: assert property (@(posedge clk_sys) disable iff (reset)
    bitTick |-> !trackWrite && stbEdge)
    else $error("bit tick while writing");
  write_mute_a: assert property (@(posedge clk_sys) disable iff (reset)
    trackWrite |=> st_r.stbCnt == 2'h0 && st_r.bitCnt == 4'h0)
    else $error("read counters run during write");
  pop_boundary_a: assert property (@(posedge clk_sys) disable iff (reset)
    fifoPop |-> ph.phi1 && trackWrite)
    else $error("character taken off a bit boundary");
  write_first_half_a: assert property (@(posedge clk_sys) disable iff (reset)
    fifoPop |=> wrSerial == !$past(fifoData[7]))
    else $error("first half cell not inverted");
  mid_cell_flip_a: assert property (@(posedge clk_sys) disable iff (reset)
    wrActive && ph.phi2 |=> wrSerial != $past(wrSerial))
    else $error("no mid-cell transition");
  parity_cells_a: assert property (@(posedge clk_sys) disable iff (reset)
    wrActive && ph.phi2 && st_r.wrIdx >= DATA_LAST |=> wrSerial == st_r.wrPar)
    else $error("parity cell level wrong");
  write_step_a: assert property (@(posedge clk_sys) disable iff (reset)
    wrActive && ph.phi1 && st_r.wrIdx < LOAD_BIT |=> st_r.wrIdx == $past(st_r.wrIdx) + 4'h1)
    else $error("write bit index did not advance");
  write_ends_a: assert property (@(posedge clk_sys) disable iff (reset)
    wrActive && ph.phi1 && st_r.wrIdx == LOAD_BIT && !fifoPop |=> !wrActive)
    else $error("serializer ran past the frame");
  subphase_after_a: assert property (@(posedge clk_sys) disable iff (reset)
    ph.phi1A || ph.phi1B |-> $past(ph.phi1))
    else $error("sub-phase without phase one");

  read_char_c: cover property (@(posedge clk_sys) disable iff (reset) hostRdValid);
  parity_bad_c: cover property (@(posedge clk_sys) disable iff (reset) $rose(parityErr));
  write_done_c: cover property (@(posedge clk_sys) disable iff (reset) $fell(wrActive));
  fifo_full_c: cover property (@(posedge clk_sys) disable iff (reset) !hostWrReady);
  sync_found_c: cover property (@(posedge clk_sys) disable iff (reset) $rose(rdSynced));
endmodule : tape_char_serdes_timing
`default_nettype wire

// ===== bench/tape_deck_model.sv
// Purpose: deck side model with read strobes, write decoder and motor decode
// Assumes: a read strobe every 16 clocks, a write cell of 1250 clocks
// Notes:   idle read level toggles so no stale value is ever seen
`timescale 1ns/1ps
`default_nettype none
module tape_deck_model (
  input  wire logic  clk_sys,
  output logic       rdStrobeN,
  output logic       rdLevel,
  input  wire logic  wrSerial,
  input  wire logic  wrActive,
  input  wire logic  dirOut,
  input  wire logic  speedOut,
  input  wire logic  runOut,
  output logic [6:0] motorCmd
);
  logic       busy;
  logic [9:0] wrQ[$];
  int         codeErrs;

  // fast fwd/rev, slow fwd/rev, brake fwd/rev, motion
  assign motorCmd = {runOut & speedOut & ~dirOut, runOut & speedOut & dirOut,
                     runOut & ~speedOut & ~dirOut, runOut & ~speedOut & dirOut,
                     ~runOut & ~dirOut, ~runOut & dirOut, runOut};

  initial begin
    rdStrobeN = 1'b1;
    rdLevel   = 1'b0;
    busy      = 1'b0;
    codeErrs  = 0;
  end

  always @(posedge clk_sys) begin
    if (!busy) begin
      rdLevel <= #10 ~rdLevel;
    end
  end

  // active low pulse, twice per bit cell; level held while low
  task automatic strobe(input logic lvl);
    rdLevel   = lvl;
    rdStrobeN = 1'b0;
    repeat (2) @(posedge clk_sys);
    #10;
    rdStrobeN = 1'b1;
    rdLevel   = ~lvl;
    repeat (14) @(posedge clk_sys);
    #10;
  endtask : strobe

  task automatic sync();
    busy = 1'b1;
    strobe(1'b1);
    strobe(1'b0);
    strobe(1'b1);
    busy = 1'b0;
  endtask : sync

  // boundary strobe then mid-cell strobe carrying the bit
  task automatic frame(input logic [7:0] d, input logic pa, input logic pb);
    busy = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      strobe(~d[i]);
      strobe(d[i]);
    end
    strobe(~pa);
    strobe(pa);
    strobe(~pb);
    strobe(pb);
    busy = 1'b0;
  endtask : frame

  initial begin : wr_decode
    logic [9:0] bits;
    logic       half;
    forever begin
      @(posedge clk_sys);
      #1;
      while (wrActive === 1'b1) begin
        for (int i = 9; i >= 0; i--) begin
          repeat (312) @(posedge clk_sys);
          #1;
          half = wrSerial;
          repeat (625) @(posedge clk_sys);
          #1;
          if (half === wrSerial) begin
            codeErrs++;
          end
          bits[i] = wrSerial;
          repeat (313) @(posedge clk_sys);
          #1;
        end
        wrQ.push_back(bits);
      end
    end
  end
endmodule : tape_deck_model
`default_nettype wire

// ===== bench/tape_char_serdes_timing_tb.sv
// Purpose: self-checking bench for the tape character path
// Assumes: deck model drives the read side, bench drives host and controls
// Notes:   only three written characters drained, a full drain costs 100k cycles
`timescale 1ns/1ps
`default_nettype none
module tape_char_serdes_timing_tb;
  import tape_pkg::*;
  logic       clk_sys, reset, hostWrValid, hostWrReady, hostRdValid, parityErr;
  logic       rdSynced, rdStrobeN, rdLevel, trackSelB, writeMode, trackAEn, trackBEn;
  logic       trackWrite, wrSerial, wrActive, dirIn, speedIn, runIn, dirOut, speedOut;
  logic       runOut;
  logic [7:0] hostWrData, hostRdData;
  logic [6:0] motorCmd;
  logic [7:0] rdQ[$];
  int         fail_count, checks;

  tape_char_serdes_timing DUT (
    .clk_sys(clk_sys), .reset(reset), .hostWrData(hostWrData), .hostWrValid(hostWrValid),
    .hostWrReady(hostWrReady), .hostRdData(hostRdData), .hostRdValid(hostRdValid),
    .parityErr(parityErr), .rdSynced(rdSynced), .rdStrobeN(rdStrobeN), .rdLevel(rdLevel),
    .trackSelB(trackSelB), .writeMode(writeMode), .trackAEn(trackAEn), .trackBEn(trackBEn),
    .trackWrite(trackWrite), .wrSerial(wrSerial), .wrActive(wrActive), .dirIn(dirIn),
    .speedIn(speedIn), .runIn(runIn), .dirOut(dirOut), .speedOut(speedOut), .runOut(runOut)
  );

  tape_deck_model deck (
    .clk_sys(clk_sys), .rdStrobeN(rdStrobeN), .rdLevel(rdLevel), .wrSerial(wrSerial),
    .wrActive(wrActive), .dirOut(dirOut), .speedOut(speedOut), .runOut(runOut),
    .motorCmd(motorCmd)
  );

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (hostRdValid === 1'b1) begin
      rdQ.push_back(hostRdData);
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #10;
  endtask : tick

  task automatic cmpFlag(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmpFlag

  task automatic cmpData(input logic [9:0] got, input logic [9:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmpData

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  task automatic hung();
    fail_count++;
    $display("CHECK FAILED at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    stop_test();
  endtask : hung

  // valid stays up between bytes; caller lowers it
  task automatic push(input logic [7:0] d);
    hostWrData  = d;
    hostWrValid = 1'b1;
    for (int n = 0; n < 50 && hostWrReady !== 1'b1; n++) begin
      tick(1);
    end
    if (hostWrReady !== 1'b1) begin
      hung();
    end
    tick(1);
  endtask : push

  initial begin
    #9_000_000;
    hung();
  end

  initial begin : main
    logic [7:0] d;
    logic [9:0] w;
    logic       p;
    logic [7:0] wrExp[$];
    fail_count  = 0;
    checks      = 0;
    reset       = 1'b1;
    hostWrData  = 8'h00;
    hostWrValid = 1'b0;
    trackSelB   = 1'b0;
    writeMode   = 1'b0;
    {dirIn, speedIn, runIn} = 3'h0;
    void'($urandom(32'h46449F71));
    tick(8);
    cmpFlag(trackAEn, 1'b1);
    cmpFlag(trackBEn, 1'b0);
    cmpFlag(hostWrReady, 1'b1);
    cmpFlag(rdSynced, 1'b0);
    cmpFlag(wrActive, 1'b0);
    reset = 1'b0;
    for (int i = 0; i < 4; i++) begin
      {writeMode, trackSelB} = 2'(i);
      {dirIn, speedIn, runIn} = 3'($urandom);
      tick(2);
      cmpFlag(trackBEn, trackSelB);
      cmpFlag(trackAEn, ~trackSelB);
      cmpFlag(trackWrite, writeMode);
      cmpData({7'h00, dirOut, speedOut, runOut}, {7'h00, dirIn, speedIn, runIn});
      cmpFlag(motorCmd[0], runIn);
    end
    $display("test track and motor done");
    writeMode = 1'b0;
    tick(2);
    deck.sync();
    cmpFlag(rdSynced, 1'b1);
    for (int k = 0; k < 4; k++) begin
      d = (k == 0) ? 8'h7A : (k == 1) ? 8'h00 : (k == 2) ? 8'hFF : 8'($urandom);
      p = ^d ^ PARITY_ODD;
      deck.frame(d, p ^ (k == 1 || k == 2), p ^ (k == 2));
      w = (rdQ.size() > 0) ? {2'b00, rdQ.pop_front()} : 'x;
      cmpData(w, {2'b00, d});
      cmpFlag(rdQ.size() == 0, 1'b1);
      cmpFlag(parityErr, k == 1 || k == 2);
    end
    $display("test read frames done");
    writeMode = 1'b1;
    tick(2);
    deck.sync();
    deck.frame(8'h5A, 1'b1, 1'b1);
    cmpFlag(rdSynced, 1'b0);
    cmpFlag(rdQ.size() == 0, 1'b1);
    $display("test read while writing done");
    writeMode = 1'b0;
    for (int k = 0; k < FIFO_DEPTH; k++) begin
      d = 8'($urandom);
      wrExp.push_back(d);
      push(d);
    end
    hostWrData = 8'hC3;
    tick(2);
    cmpFlag(hostWrReady, 1'b0);
    hostWrValid = 1'b0;
    writeMode   = 1'b1;
    for (int n = 0; n < 41000 && deck.wrQ.size() < 3; n++) begin
      tick(1);
    end
    if (deck.wrQ.size() < 3) begin
      hung();
    end
    cmpFlag(hostWrReady, 1'b1);
    cmpFlag(deck.codeErrs == 0, 1'b1);
    for (int k = 0; k < 3; k++) begin
      p = ^wrExp[k] ^ PARITY_ODD;
      cmpData(deck.wrQ.pop_front(), {wrExp[k], p, p});
    end
    $display("test write serializer done");
    reset = 1'b1;
    tick(2);
    cmpFlag(wrActive, 1'b0);
    cmpFlag(hostWrReady, 1'b1);
    cmpFlag(trackAEn, 1'b1);
    reset = 1'b0;
    tick(2);
    $display("test reset mid write done");
    stop_test();
  end
endmodule : tape_char_serdes_timing_tb
`default_nettype wire
